// [design/sdr_arbiter.v]
// Channel arbiter: highest priority level first, lowest channel number on a tie
`timescale 1ns/1ps
`default_nettype none
module sdr_arbiter (
    input wire [6:0] pend,
    input wire [13:0] prio,
    output reg gnt_vld,
    output reg [2:0] gnt_ch
);
    integer i;
    reg [1:0] best;

    // Scanning downward with >= lets the lower channel take equal levels
    always @* begin
        gnt_vld = 1'b0;
        gnt_ch = 3'h0;
        best = 2'h0;
        for (i = 6; i >= 0; i = i - 1) begin
            if (pend[i] && (!gnt_vld || prio[2*i +: 2] >= best)) begin // see RQ4 see RQ5
                gnt_vld = 1'b1;
                gnt_ch = i[2:0];
                best = prio[2*i +: 2];
            end
        end
    end
endmodule // sdr_arbiter
`default_nettype wire

// [design/sdr_consts.vh]
// Register offsets, field positions and reset values of the seven-channel transfer controller
`ifndef SDR_CONSTS_VH
`define SDR_CONSTS_VH

`define SDR_NCH 7
`define SDR_NPER 16
`define SDR_NTRIG 4

`define SDR_OFF_ISR 12'h000
`define SDR_OFF_IMR 12'h004
`define SDR_OFF_CFG 2'h0
`define SDR_OFF_CNT 2'h1
`define SDR_OFF_SRC 2'h2
`define SDR_OFF_DST 2'h3

`define SDR_CFG_EN 0
`define SDR_CFG_CIRC 1
`define SDR_CFG_SINC 2
`define SDR_CFG_DINC 3
`define SDR_CFG_SSIZE 4
`define SDR_CFG_DSIZE 6
`define SDR_CFG_PRIO 8
`define SDR_CFG_M2M 10
`define SDR_CFG_SEL 11
`define SDR_CFG_W 16

`define SDR_FLG_TC 0
`define SDR_FLG_HT 1
`define SDR_FLG_TE 2
`define SDR_FLG_W 21

`define SDR_SIZE_BYTE 2'h0
`define SDR_SIZE_HALF 2'h1
`define SDR_SIZE_WORD 2'h2

`define SDR_CFG_RST 16'h0000
`define SDR_CNT_RST 17'h00000
`define SDR_ADDR_RST 32'h00000000
`define SDR_FLG_RST 21'h000000

`endif

// [design/sdr_dma.v]
// Seven-channel transfer controller with request router, APB registers and memory master port
//
// What this block does
// RQ1: Seven channels, each with its own configuration and one routed request.
// RQ2: Any peripheral request line can be routed to any channel by software.
// RQ3: A hardware trigger can also be routed to start or pace a channel.
// RQ4: Each channel has one of four priority levels; highest pending level wins.
// RQ5: Equal levels resolve to the lower-numbered channel.
// RQ6: Source and destination sizes chosen separately; data packed or unpacked between them (the block truncates or zero-pads each item instead).
// RQ7: Software gives addresses aligned to the configured item sizes.
// RQ8: Circular mode traverses the buffer repeatedly instead of stopping.
// RQ9: Half, complete and error flags per channel, ORed into one channel interrupt.
// RQ10: Memory and peripheral targets in any direction combination are supported.
// RQ11: Flash, SRAM and bus peripherals are all reachable as source or destination.
// RQ12: Programmable item count per channel, at most 65536 items.
// RQ13: Count decrements per item; half flag at midpoint, complete flag at zero.
// RQ14: Circular mode reloads count and start addresses at zero and keeps going.
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.vh"
module sdr_dma (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire [15:0] periph_req,
    input wire [3:0] hw_trig,
    output reg [6:0] req_ack,
    output reg mem_req,
    output reg mem_write,
    output reg [31:0] mem_addr,
    output reg [1:0] mem_size,
    output reg [31:0] mem_wdata,
    input wire [31:0] mem_rdata,
    input wire mem_ack,
    input wire mem_err,
    output wire [6:0] ch_irq,
    output wire irq
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RD = 2'h1;
    localparam ST_WR = 2'h2;

    reg [15:0] cfg_r [0:6];
    reg [16:0] cnt_prog_r [0:6];
    reg [16:0] cnt_rem_r [0:6];
    reg [31:0] src_base_r [0:6];
    reg [31:0] src_cur_r [0:6];
    reg [31:0] dst_base_r [0:6];
    reg [31:0] dst_cur_r [0:6];
    reg [20:0] isr_r;
    reg [20:0] imr_r;
    reg [20:0] flag_set;
    reg [20:0] isr_nxt;
    reg [6:0] trig_pend_r;
    reg [6:0] trig_pend_nxt;
    reg [3:0] trig_d_r;
    reg [1:0] state_r;
    reg [2:0] act_r;
    reg [31:0] rd_val;
    reg rd_ok;
    wire [6:0] pend;
    wire [6:0] route_req;
    wire [6:0] trig_rise;
    wire [13:0] prio_vec;
    wire gnt_vld;
    wire [2:0] gnt_ch;
    wire apb_wr;
    wire apb_setup;
    wire item_done;
    wire item_err;
    wire [16:0] rem_dec;
    wire [16:0] half_pt;
    wire [15:0] act_cfg;
    integer i;

    function is_chan;
        input [11:0] a;
        begin
            is_chan = (a[11:7] == 5'h00) && (a[6:4] != 3'h0);
        end
    endfunction

    function [2:0] chan_of;
        input [11:0] a;
        begin
            chan_of = a[6:4] - 3'h1;
        end
    endfunction

    function [31:0] size_mask;
        input [1:0] s;
        begin
            case (s)
                `SDR_SIZE_BYTE: size_mask = 32'h000000ff;
                `SDR_SIZE_HALF: size_mask = 32'h0000ffff;
                default: size_mask = 32'hffffffff;
            endcase
        end
    endfunction

    function [31:0] size_step;
        input [1:0] s;
        begin
            case (s)
                `SDR_SIZE_BYTE: size_step = 32'h00000001;
                `SDR_SIZE_HALF: size_step = 32'h00000002;
                default: size_step = 32'h00000004;
            endcase
        end
    endfunction

    assign pready = 1'b1;
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign irq = |(isr_r & imr_r);

    // Per-channel routing: selector 0..15 picks a peripheral line, 16..19 a trigger
    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : g_chan
            wire [4:0] sel = cfg_r[g][`SDR_CFG_SEL +: 5];
            assign route_req[g] = sel[4] ? trig_pend_r[g] : periph_req[sel[3:0]]; // see RQ2 see RQ3
            assign trig_rise[g] = sel[4] && hw_trig[sel[1:0]] && !trig_d_r[sel[1:0]]; // see RQ3
            // A channel just acked is masked one cycle so a level request can drop
            assign pend[g] = cfg_r[g][`SDR_CFG_EN] && (cnt_rem_r[g] != 17'h00000) && !req_ack[g] &&
                (cfg_r[g][`SDR_CFG_M2M] || route_req[g]); // see RQ1 see RQ10
            assign prio_vec[2*g +: 2] = cfg_r[g][`SDR_CFG_PRIO +: 2];
            assign ch_irq[g] = |isr_r[3*g +: 3]; // see RQ9
        end
    endgenerate

    sdr_arbiter u_arb (
        .pend(pend),
        .prio(prio_vec),
        .gnt_vld(gnt_vld),
        .gnt_ch(gnt_ch)
    );

    assign act_cfg = cfg_r[act_r];
    assign item_done = (state_r == ST_WR) && mem_ack && !mem_err;
    assign item_err = (state_r != ST_IDLE) && mem_ack && mem_err;
    assign rem_dec = cnt_rem_r[act_r] - 17'h00001; // see RQ13
    assign half_pt = {1'b0, cnt_prog_r[act_r][16:1]};

    // Hardware set wins over a software clear in the same cycle
    always @* begin
        flag_set = `SDR_FLG_RST;
        if (item_done) begin
            flag_set[3*act_r + `SDR_FLG_TC] = (rem_dec == 17'h00000); // see RQ13
            flag_set[3*act_r + `SDR_FLG_HT] = (rem_dec == half_pt); // see RQ13
        end
        if (item_err) begin
            flag_set[3*act_r + `SDR_FLG_TE] = 1'b1; // see RQ9
        end
        isr_nxt = isr_r;
        if (apb_wr && paddr == `SDR_OFF_ISR) begin
            isr_nxt = isr_r & ~pwdata[20:0];
        end
        isr_nxt = isr_nxt | flag_set; // see RQ9
        trig_pend_nxt = trig_pend_r;
        if (item_done) begin
            trig_pend_nxt[act_r] = 1'b0;
        end
        trig_pend_nxt = trig_pend_nxt | trig_rise;
    end

    // Register read decode; unmapped or misaligned offsets answer with an error
    always @* begin
        rd_val = 32'h00000000;
        rd_ok = 1'b1;
        if (paddr[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (paddr == `SDR_OFF_ISR) begin
            rd_val = {11'h000, isr_r};
        end else if (paddr == `SDR_OFF_IMR) begin
            rd_val = {11'h000, imr_r};
        end else if (is_chan(paddr)) begin
            case (paddr[3:2])
                `SDR_OFF_CFG: rd_val = {16'h0000, cfg_r[chan_of(paddr)]};
                `SDR_OFF_CNT: rd_val = {15'h0000, cnt_rem_r[chan_of(paddr)]};
                `SDR_OFF_SRC: rd_val = src_cur_r[chan_of(paddr)];
                default: rd_val = dst_cur_r[chan_of(paddr)];
            endcase
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read data is captured in the setup cycle so the slave never waits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            isr_r <= `SDR_FLG_RST;
            imr_r <= `SDR_FLG_RST;
            trig_pend_r <= 7'h00;
            trig_d_r <= 4'h0;
        end else begin
            if (apb_setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_val;
                pslverr <= !rd_ok;
            end
            isr_r <= isr_nxt;
            if (apb_wr && paddr == `SDR_OFF_IMR) begin
                imr_r <= pwdata[20:0];
            end
            trig_pend_r <= trig_pend_nxt;
            trig_d_r <= hw_trig;
        end
    end

    // Channel state: engine updates first, a software write in the same cycle overrides
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 7; i = i + 1) begin
                cfg_r[i] <= `SDR_CFG_RST;
                cnt_prog_r[i] <= `SDR_CNT_RST;
                cnt_rem_r[i] <= `SDR_CNT_RST;
                src_base_r[i] <= `SDR_ADDR_RST;
                src_cur_r[i] <= `SDR_ADDR_RST;
                dst_base_r[i] <= `SDR_ADDR_RST;
                dst_cur_r[i] <= `SDR_ADDR_RST;
            end
        end else begin
            if (item_err) begin
                cfg_r[act_r][`SDR_CFG_EN] <= 1'b0;
            end
            if (item_done) begin
                if (rem_dec == 17'h00000 && act_cfg[`SDR_CFG_CIRC]) begin
                    cnt_rem_r[act_r] <= cnt_prog_r[act_r]; // see RQ8 see RQ14
                    src_cur_r[act_r] <= src_base_r[act_r]; // see RQ14
                    dst_cur_r[act_r] <= dst_base_r[act_r]; // see RQ14
                end else begin
                    cnt_rem_r[act_r] <= rem_dec; // see RQ13
                    if (act_cfg[`SDR_CFG_SINC]) begin
                        src_cur_r[act_r] <= src_cur_r[act_r] + size_step(act_cfg[`SDR_CFG_SSIZE +: 2]);
                    end
                    if (act_cfg[`SDR_CFG_DINC]) begin
                        dst_cur_r[act_r] <= dst_cur_r[act_r] + size_step(act_cfg[`SDR_CFG_DSIZE +: 2]);
                    end
                end
            end
            if (apb_wr && is_chan(paddr) && paddr[1:0] == 2'h0) begin
                case (paddr[3:2])
                    `SDR_OFF_CFG: cfg_r[chan_of(paddr)] <= pwdata[15:0]; // see RQ1 see RQ4
                    `SDR_OFF_CNT: begin
                        // Values above 65536 are clipped so the count never exceeds its limit
                        if (pwdata[31:16] != 16'h0000 && pwdata[31:0] > 32'h00010000) begin
                            cnt_prog_r[chan_of(paddr)] <= 17'h10000; // see RQ12
                            cnt_rem_r[chan_of(paddr)] <= 17'h10000;
                        end else begin
                            cnt_prog_r[chan_of(paddr)] <= pwdata[16:0]; // see RQ12
                            cnt_rem_r[chan_of(paddr)] <= pwdata[16:0];
                        end
                    end
                    // Low address bits are kept as written; alignment is software's duty
                    `SDR_OFF_SRC: begin
                        src_base_r[chan_of(paddr)] <= pwdata; // see RQ7 see RQ11
                        src_cur_r[chan_of(paddr)] <= pwdata;
                    end
                    default: begin
                        dst_base_r[chan_of(paddr)] <= pwdata; // see RQ7 see RQ11
                        dst_cur_r[chan_of(paddr)] <= pwdata;
                    end
                endcase
            end
        end
    end

    // Transfer engine: one item at a time, read then write, held until acknowledged
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            act_r <= 3'h0;
            req_ack <= 7'h00;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 32'h00000000;
            mem_size <= 2'h0;
            mem_wdata <= 32'h00000000;
        end else begin
            req_ack <= 7'h00;
            case (state_r)
                ST_IDLE: begin
                    if (gnt_vld) begin
                        act_r <= gnt_ch;
                        mem_req <= 1'b1;
                        mem_write <= 1'b0;
                        mem_addr <= src_cur_r[gnt_ch]; // see RQ10 see RQ11
                        mem_size <= cfg_r[gnt_ch][`SDR_CFG_SSIZE +: 2]; // see RQ6
                        state_r <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (mem_ack && mem_err) begin
                        mem_req <= 1'b0;
                        state_r <= ST_IDLE;
                    end else if (mem_ack) begin
                        // Narrowing truncates, widening pads with zeros
                        mem_wdata <= mem_rdata & size_mask(act_cfg[`SDR_CFG_SSIZE +: 2]) &
                            size_mask(act_cfg[`SDR_CFG_DSIZE +: 2]); // see RQ6
                        mem_write <= 1'b1;
                        mem_addr <= dst_cur_r[act_r];
                        mem_size <= act_cfg[`SDR_CFG_DSIZE +: 2]; // see RQ6
                        state_r <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_write <= 1'b0;
                        state_r <= ST_IDLE;
                        if (!mem_err) begin
                            req_ack[act_r] <= 1'b1;
                        end
                    end
                end
                default: begin
                    mem_req <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // sdr_dma
`default_nettype wire

// [sim/sdr_dma_sva.sv]
// Port checker for the seven-channel transfer controller
`timescale 1ns/1ps
`default_nettype none
module sdr_dma_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire mem_req,
    input wire mem_write,
    input wire [31:0] mem_addr,
    input wire mem_ack,
    input wire mem_err,
    input wire [6:0] req_ack,
    input wire [6:0] ch_irq,
    input wire irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_done; mem_req && !mem_write && mem_ack && !mem_err; endsequence
    sequence s_wr_done; mem_req && mem_write && mem_ack && !mem_err; endsequence
    sequence s_fail; mem_req && mem_ack && mem_err; endsequence
    a_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write))
        else $error("memory request changed before ack");
    a_read_first: assert property ($rose(mem_req) |-> !mem_write)
        else $error("item did not start with a read");
    a_read_then_write: assert property (s_rd_done |=> mem_req && mem_write)
        else $error("read not followed by write");
    a_idle_after_item: assert property (s_wr_done |=> !mem_req && $onehot(req_ack))
        else $error("no idle cycle or ack after item");
    a_one_ack: assert property ($onehot0(req_ack))
        else $error("several channels acknowledged");
    a_ack_has_cause: assert property (req_ack != 7'h00 |-> $past(mem_ack && mem_write && !mem_err))
        else $error("ack without completed item");
    a_fail_flags: assert property (s_fail |=> req_ack == 7'h00 && ch_irq != 7'h00)
        else $error("failed access not flagged");
    a_irq_has_flag: assert property (irq |-> ch_irq != 7'h00)
        else $error("interrupt without channel flag");
    // Flags are sticky: only a register write may take a channel flag away
    a_flag_sticky: assert property (!(psel && penable && pwrite) |=> ($past(ch_irq) & ~ch_irq) == 7'h00)
        else $error("channel flag cleared without a write");
endmodule // sdr_dma_sva
bind sdr_dma sdr_dma_sva u_sdr_dma_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_err(mem_err),
    .req_ack(req_ack), .ch_irq(ch_irq), .irq(irq));
`default_nettype wire

// [sim/sdr_mem.sv]
// Partner model: system bus memory with variable latency and peripheral request lines
`timescale 1ns/1ps
`default_nettype none
module sdr_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [1:0] mem_size,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ack,
    output logic mem_err,
    input wire logic [6:0] req_ack,
    input wire logic [15:0] raise,
    output logic [15:0] periph_req
);
    logic [7:0] mb [0:1023];
    logic [9:0] a;
    logic [31:0] rd;
    logic wait_r;
    assign a = mem_addr[9:0];
    assign rd = {mb[a + 10'd3], mb[a + 10'd2], mb[a + 10'd1], mb[a]};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            wait_r <= 1'b0;
            mem_rdata <= 32'h0;
            periph_req <= 16'h0;
        end else begin
            // Lines 0..6 drop once the channel of the same number is acknowledged; lines 7..15 stay raised
            periph_req <= (periph_req | raise) & ~{9'h0, req_ack};
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            // Released data bus shows a changing pattern
            mem_rdata <= ~mem_rdata;
            // Bit 4 of the address adds a wait state
            if (mem_req && !mem_ack && wait_r == 1'b0 && a[4]) begin
                wait_r <= 1'b1;
            end else if (mem_req && !mem_ack) begin
                wait_r <= 1'b0;
                mem_ack <= 1'b1;
                mem_err <= (mem_addr[11:8] == 4'hf);
                if (!mem_write) begin
                    mem_rdata <= mem_size[1] ? rd : (mem_size[0] ? {16'h0, rd[15:0]} : {24'h0, rd[7:0]});
                end else begin
                    mb[a] <= mem_wdata[7:0];
                    if (mem_size != 2'h0) mb[a + 10'd1] <= mem_wdata[15:8];
                    if (mem_size[1]) mb[a + 10'd2] <= mem_wdata[23:16];
                    if (mem_size[1]) mb[a + 10'd3] <= mem_wdata[31:24];
                end
            end
        end
    end
endmodule // sdr_mem
`default_nettype wire

// [sim/test_sdr_dma.sv]
// Self-checking bench for the seven-channel transfer controller
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.vh"
module test_sdr_dma;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, mem_addr, mem_wdata, mem_rdata, v;
    logic [15:0] periph_req, raise = 0;
    logic [3:0] hw_trig = 0;
    logic [6:0] req_ack, ch_irq;
    logic [1:0] mem_size;
    logic pready, pslverr, mem_req, mem_write, mem_ack, mem_err, irq, e;
    integer num_errors = 0, n_checks = 0;
    logic [31:0] rd_log [$];
    initial forever #12.5 pclk = ~pclk;
    sdr_dma u_sdr_dma (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_req(periph_req), .hw_trig(hw_trig), .req_ack(req_ack), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err), .ch_irq(ch_irq), .irq(irq));
    sdr_mem u_sdr_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .mem_err(mem_err), .req_ack(req_ack), .raise(raise), .periph_req(periph_req));
    always @(posedge pclk) if (mem_req && mem_ack && !mem_write) rd_log.push_back(mem_addr);
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer i;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        v = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (i >= 20) chk("pready", 1, 0);
        if (i >= 20) give_verdict;
    endtask
    // Polling is bounded; a stuck engine ends the run
    task poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        integer k;
        k = 0;
        do begin
            xfer(0, a, 0);
            k++;
        end while ((v & m) !== x && k < 100);
        chk("poll", x, v & m);
        if (k >= 100) give_verdict;
    endtask
    task setup(input int ch, input logic [31:0] s, input logic [31:0] d, input logic [31:0] n, input logic [15:0] c);
        logic [11:0] b;
        b = 12'h010 + 12'h010 * ch[11:0];
        xfer(1, b + 12'h8, s);
        xfer(1, b + 12'hc, d);
        xfer(1, b + 12'h4, n);
        xfer(1, b, {16'h0, c});
    endtask
    task pulse;
        hw_trig <= 4'h2;
        @(posedge pclk);
        hw_trig <= 4'h0;
    endtask
    function logic [31:0] word(input int a);
        return {u_sdr_mem.mb[a + 3], u_sdr_mem.mb[a + 2], u_sdr_mem.mb[a + 1], u_sdr_mem.mb[a]};
    endfunction
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        xfer(0, 12'h010, 0);
        chk("cfg0", `SDR_CFG_RST, v);
        xfer(0, 12'h074, 0);
        chk("cnt6", `SDR_CNT_RST, v);
        xfer(0, 12'hff0, 0);
        chk("unmapped", 1, e);
        chk("unmapped data", 0, v);
        xfer(0, 12'h012, 0);
        chk("misaligned", 1, e);
        xfer(1, 12'h014, 32'h20000);
        xfer(0, 12'h014, 0);
        chk("cnt clip", 32'h10000, v);
        for (int i = 0; i < 4; i++) u_sdr_mem.mb[256 + i] = 8'(17 * (i + 1));
        setup(0, 32'h100, 32'h200, 4, 16'h048d);
        poll(12'h000, 32'h3, 32'h3);
        chk("masked irq", 0, irq);
        chk("ch_irq0", 1, ch_irq[0]);
        for (int i = 0; i < 4; i++) chk("pad", 17 * (i + 1), word(512 + 4 * i));
        xfer(0, 12'h018, 0);
        chk("src", 32'h104, v);
        xfer(0, 12'h01c, 0);
        chk("dst", 32'h210, v);
        xfer(1, 12'h004, 32'h1);
        xfer(0, 12'h000, 0);
        chk("irq", 1, irq);
        xfer(1, 12'h000, 32'h3);
        xfer(0, 12'h000, 0);
        chk("isr clr", 0, v);
        chk("irq clr", 0, irq);
        // Disable first, or the new count would restart the channel with its old sizes
        xfer(1, 12'h010, 0);
        setup(0, 32'h100, 32'h2c0, 2, 16'h0429);
        poll(12'h000, 32'h1, 32'h1);
        xfer(0, 12'h018, 0);
        chk("src fixed", 32'h100, v);
        chk("narrow", 32'h1111, {u_sdr_mem.mb[705], u_sdr_mem.mb[704]});
        // Routed requests raised together: level first, then channel order
        for (int t = 0; t < 2; t++) begin
            setup(1 + 2 * t, 32'h304 + 8 * t, 32'h384 + 8 * t, 1, 16'((1 + 2 * t) * 2048 + 512 * t + 'had));
            setup(2 + 2 * t, 32'h308 + 8 * t, 32'h388 + 8 * t, 1, 16'((2 + 2 * t) * 2048 + (3 - t) * 256 + 'had));
            rd_log.delete();
            raise <= 16'(3 << (1 + 2 * t));
            @(posedge pclk);
            raise <= 0;
            poll(12'h000, 32'h9 << (3 + 6 * t), 32'h9 << (3 + 6 * t));
            chk("first grant", t ? 32'h30c : 32'h308, rd_log[0]);
        end
        setup(5, 32'h140, 32'h240, 2, 16'h885f);
        pulse;
        poll(12'h064, 32'h1ffff, 1);
        pulse;
        poll(12'h000, 32'h18000, 32'h18000);
        xfer(0, 12'h064, 0);
        chk("reload cnt", 2, v);
        xfer(0, 12'h068, 0);
        chk("reload src", 32'h140, v);
        pulse;
        poll(12'h064, 32'h1ffff, 1);
        xfer(0, 12'h068, 0);
        chk("src step", 32'h142, v);
        setup(6, 32'hf00, 32'h280, 3, 16'h04ad);
        poll(12'h000, 32'h100000, 32'h100000);
        xfer(0, 12'h074, 0);
        chk("cnt kept", 3, v);
        xfer(0, 12'h070, 0);
        chk("en off", 0, v & 1);
        chk("ch_irq6", 1, ch_irq[6]);
        give_verdict;
    end
endmodule // test_sdr_dma
`default_nettype wire
